// ---- hdl/spr_baud.sv ----
`timescale 1ns/10ps
`default_nettype none
module spr_baud (
  input wire logic clk_sys,
  input wire logic rstn,
  spr_baud_if.gen bi
);
  import spr_pkg::*;

  // Restart lands the first tick mid start bit, less start-detect and tick latency
  logic [PW-1:0] cnt_q;
  logic tick_q;
  wire logic [PW-1:0] half = bi.period >> 1;
  wire logic [PW-1:0] first = (half > PER_LAT) ? half - PER_LAT : '0;
  wire logic at_zero = (cnt_q == '0);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (bi.restart) begin
      cnt_q <= first;
      tick_q <= 1'b0;
    end else if (!bi.run) begin
      tick_q <= 1'b0;
    end else if (at_zero) begin
      cnt_q <= bi.period - PER_ONE;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - PER_ONE;
      tick_q <= 1'b0;
    end
  end

  assign bi.tick = tick_q;
endmodule
`default_nettype wire

// ---- hdl/spr_baud_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface spr_baud_if;
  import spr_pkg::*;
  logic restart;
  logic run;
  logic [PW-1:0] period;
  logic tick;
  modport ctl (output restart, output run, output period, input tick);
  modport gen (input restart, input run, input period, output tick);
endinterface
`default_nettype wire

// ---- hdl/spr_pkg.sv ----
package spr_pkg;

  //////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int AW = 6;
  localparam int DW = 32;
  localparam int PW = 24;

  //////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [AW-1:0] OFS_BAUD_CONTROL = 6'h00;
  localparam logic [AW-1:0] OFS_PERIPHERAL_IRQ_ENABLE_1 = 6'h04;
  localparam logic [AW-1:0] OFS_PERIPHERAL_IRQ_FLAGS_1 = 6'h08;
  localparam logic [AW-1:0] OFS_RX_DATA = 6'h0c;
  localparam logic [AW-1:0] OFS_RX_STATUS = 6'h10;
  localparam logic [AW-1:0] OFS_TX_STATUS = 6'h14;
  localparam logic [AW-1:0] OFS_DIV_LOW = 6'h18;
  localparam logic [AW-1:0] OFS_DIV_HIGH = 6'h1c;
  localparam logic [AW-1:0] OFS_IRQ_CONTROL = 6'h20;

  //////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int RC_PORT_ENABLE = 7;
  localparam int RC_RX9 = 6;
  localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RC_ADDRESS_DETECT_ENABLE = 3;
  localparam int TX_CLOCK_SOURCE_MASTER = 7;
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED_BAUD = 2;
  localparam int BC_WIDE_BAUD_DIVISOR = 3;
  localparam int PI_RX_DONE_IRQ_ENABLE = 5;
  localparam int IC_GIE = 7;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BE_LOW = 0;

  //////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [DW-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [PW-1:0] PER_ONE = 24'h00_0001;
  localparam logic [PW-1:0] PER_LAT = 24'h00_0003;
  localparam int SH_X4 = 2;
  localparam int SH_X16 = 4;
  localparam int SH_X64 = 6;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } spr_state_t;

endpackage

// ---- hdl/spr_rx_top.sv ----
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module spr_rx_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [spr_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [spr_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [spr_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sync_data_pin,
  input wire logic sync_clk_pin,
  input wire logic core_sleep,
  output logic wake_req,
  output logic irq_req
);
  import spr_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Register state
  logic port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q;
  logic clock_source_master_q, sync_q, high_speed_baud_q, wide_baud_divisor_q;
  logic rx_done_irq_enable_q, gie_q, peripheral_irq_enable_q;
  logic [7:0] div_lo_q, div_hi_q;
  logic rx_done_flag_q, overrun_error_q, framing_error_q, received_ninth_bit_q;
  logic [7:0] rxbuf_q;
  logic [DW-1:0] rdata_q;
  logic wait_q, irq_q, wake_q;

  // Receiver state
  spr_state_t st_q, st_d;
  logic [8:0] sh_q, sh_d;
  logic [3:0] bcnt_q, bcnt_d;
  logic rx_prev_q, ck_prev_q;
  logic [1:0] pins_s;
  logic restart;

  spr_baud_if bif ();

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bit-rate timer
  spr_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({sync_data_pin, sync_clk_pin}),
    .q(pins_s)
  );

  spr_baud u_baud (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .bi(bif.gen)
  );

  wire logic dt_s = pins_s[1];
  wire logic ck_s = pins_s[0];

  //////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic wr = avs_write && !wait_q && avs_byteenable[BE_LOW];
  wire logic rd = avs_read && !wait_q;
  wire logic hit_bc = (avs_address == OFS_BAUD_CONTROL);
  wire logic hit_pie = (avs_address == OFS_PERIPHERAL_IRQ_ENABLE_1);
  wire logic hit_pir = (avs_address == OFS_PERIPHERAL_IRQ_FLAGS_1);
  wire logic hit_rxd = (avs_address == OFS_RX_DATA);
  wire logic hit_rcs = (avs_address == OFS_RX_STATUS);
  wire logic hit_txs = (avs_address == OFS_TX_STATUS);
  wire logic hit_dlo = (avs_address == OFS_DIV_LOW);
  wire logic hit_dhi = (avs_address == OFS_DIV_HIGH);
  wire logic hit_ic = (avs_address == OFS_IRQ_CONTROL);
  wire logic rd_buf = rd && hit_rxd;
  wire logic [7:0] wbyte = avs_writedata[7:0];

  //////////////////////////////////////////////////////////////////////
  // Bit rate: (divisor + 1) times a prescale of 64, 16 or 4
  wire logic [15:0] div_val = wide_baud_divisor_q ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
  wire logic [PW-1:0] div_p1 = {8'h00, div_val} + PER_ONE;
  wire logic [PW-1:0] period =
    (high_speed_baud_q && wide_baud_divisor_q) ? (div_p1 << SH_X4) :
    (high_speed_baud_q || wide_baud_divisor_q) ? (div_p1 << SH_X16) : (div_p1 << SH_X64);

  //////////////////////////////////////////////////////////////////////
  // Receiver control
  wire logic rx_on = port_enable_q && continuous_receive_enable_q;
  wire logic async_on = rx_on && !sync_q && !overrun_error_q && !core_sleep;
  wire logic slave_on = rx_on && sync_q && !clock_source_master_q && !overrun_error_q;
  wire logic rx_active = async_on || slave_on;
  wire logic rx_fall = rx_prev_q && !dt_s;
  wire logic ck_fall = ck_prev_q && !ck_s;
  wire logic [3:0] nbits = rx9_q ? BITS_9 : BITS_8;
  wire logic bit_last = (bcnt_q == nbits - CNT_ONE);
  wire logic [8:0] sh_in = {dt_s, sh_q[8:1]};
  wire logic [8:0] char_src = sync_q ? sh_in : sh_q;
  wire logic [7:0] char_data = rx9_q ? char_src[7:0] : char_src[8:1];
  wire logic char_ninth = rx9_q && char_src[8];
  wire logic rx_deliver = slave_on ? (ck_fall && bit_last) :
                          (async_on && (st_q == ST_STOP) && bif.tick);
  wire logic buf_full = rx_done_flag_q && !rd_buf;
  wire logic addr_drop = address_detect_enable_q && rx9_q && !char_ninth;
  wire logic ovr_set = rx_deliver && buf_full;
  wire logic deliver_ok = rx_deliver && !buf_full && !addr_drop;
  wire logic stop_low = !sync_q && !dt_s;
  wire logic rx_idle = (st_q == ST_IDLE) && !(rx_on && sync_q);

  assign bif.restart = restart;
  assign bif.run = async_on && !sync_q;
  assign bif.period = period;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bcnt_d = bcnt_q;
    restart = 1'b0;
    if (!rx_active) begin
      st_d = ST_IDLE;
      bcnt_d = '0;
    end else if (sync_q) begin
      st_d = ST_IDLE;
      if (ck_fall) begin
        sh_d = sh_in;
        bcnt_d = bit_last ? 4'h0 : bcnt_q + CNT_ONE;
      end
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (rx_fall) begin
            restart = 1'b1;
            st_d = ST_START;
          end
        end
        ST_START: begin
          if (bif.tick) begin
            st_d = dt_s ? ST_IDLE : ST_DATA;
            bcnt_d = '0;
          end
        end
        ST_DATA: begin
          if (bif.tick) begin
            sh_d = sh_in;
            bcnt_d = bit_last ? 4'h0 : bcnt_q + CNT_ONE;
            st_d = bit_last ? ST_STOP : ST_DATA;
          end
        end
        ST_STOP: begin
          if (bif.tick) begin
            st_d = ST_IDLE;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      sh_q <= '0;
      bcnt_q <= '0;
      rx_prev_q <= 1'b1;
      ck_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bcnt_q <= bcnt_d;
      rx_prev_q <= dt_s;
      ck_prev_q <= ck_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Receive buffer and flags; a new character wins over a clearing read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_done_flag_q <= 1'b0;
      overrun_error_q <= 1'b0;
      framing_error_q <= 1'b0;
      received_ninth_bit_q <= 1'b0;
      rxbuf_q <= BYTE_RST;
    end else begin
      rx_done_flag_q <= port_enable_q && (deliver_ok || (rx_done_flag_q && !rd_buf));
      overrun_error_q <= rx_on && (overrun_error_q || ovr_set);
      if (!port_enable_q) begin
        framing_error_q <= 1'b0;
        received_ninth_bit_q <= 1'b0;
      end else if (deliver_ok) begin
        framing_error_q <= stop_low;
        received_ninth_bit_q <= char_ninth;
        rxbuf_q <= char_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt and wake outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= rx_done_flag_q && rx_done_irq_enable_q && peripheral_irq_enable_q && gie_q;
      wake_q <= rx_done_flag_q && rx_done_irq_enable_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q} <= '0;
      {clock_source_master_q, sync_q, high_speed_baud_q, wide_baud_divisor_q} <= '0;
      {rx_done_irq_enable_q, gie_q, peripheral_irq_enable_q} <= '0;
      div_lo_q <= BYTE_RST;
      div_hi_q <= BYTE_RST;
    end else if (wr) begin
      if (hit_rcs) begin
        port_enable_q <= wbyte[RC_PORT_ENABLE];
        rx9_q <= wbyte[RC_RX9];
        single_receive_enable_q <= wbyte[RC_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_q <= wbyte[RC_CONTINUOUS_RECEIVE_ENABLE];
        address_detect_enable_q <= wbyte[RC_ADDRESS_DETECT_ENABLE];
      end else if (hit_txs) begin
        clock_source_master_q <= wbyte[TX_CLOCK_SOURCE_MASTER];
        sync_q <= wbyte[TX_SYNC];
        high_speed_baud_q <= wbyte[TX_HIGH_SPEED_BAUD];
      end else if (hit_bc) begin
        wide_baud_divisor_q <= wbyte[BC_WIDE_BAUD_DIVISOR];
      end else if (hit_pie) begin
        rx_done_irq_enable_q <= wbyte[PI_RX_DONE_IRQ_ENABLE];
      end else if (hit_ic) begin
        gie_q <= wbyte[IC_GIE];
        peripheral_irq_enable_q <= wbyte[IC_PERIPHERAL_IRQ_ENABLE];
      end else if (hit_dlo) begin
        div_lo_q <= wbyte;
      end else if (hit_dhi) begin
        div_hi_q <= wbyte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  logic [7:0] rbyte;
  always_comb begin
    rbyte = BYTE_RST;
    if (hit_rcs) begin
      rbyte = {port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q, framing_error_q, overrun_error_q, received_ninth_bit_q};
    end else if (hit_rxd) begin
      rbyte = rxbuf_q;
    end else if (hit_pir) begin
      rbyte = {2'b00, rx_done_flag_q, 5'b00000};
    end else if (hit_pie) begin
      rbyte = {2'b00, rx_done_irq_enable_q, 5'b00000};
    end else if (hit_txs) begin
      rbyte = {clock_source_master_q, 3'b000, sync_q, high_speed_baud_q, 2'b00};
    end else if (hit_bc) begin
      rbyte = {1'b0, rx_idle, 2'b00, wide_baud_divisor_q, 3'b000};
    end else if (hit_ic) begin
      rbyte = {gie_q, peripheral_irq_enable_q, 6'b000000};
    end else if (hit_dlo) begin
      rbyte = div_lo_q;
    end else if (hit_dhi) begin
      rbyte = div_hi_q;
    end
  end

  // One wait cycle per request, then one cycle with waitrequest low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'b1;
      rdata_q <= WORD_ZERO;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= {24'h00_0000, rbyte};
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq_req = irq_q;
  assign wake_req = wake_q;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_char_done;
    deliver_ok;
  endsequence

  sequence s_flag_up;
    rx_done_flag_q ##1 (wake_q == rx_done_irq_enable_q);
  endsequence

  rx_gate_off_a: assert property (
    !rx_on |=> (st_q == ST_IDLE) && (bcnt_q == 4'h0))
    else $error("receiver not idle with reception disabled");

  done_flag_set_a: assert property (
    s_char_done |=> s_flag_up)
    else $error("receive-done flag or wake missing after character");

  buf_load_a: assert property (
    deliver_ok |=> rxbuf_q == $past(char_data))
    else $error("receive buffer does not hold the character");

  ovr_clear_a: assert property (
    !continuous_receive_enable_q |=> !overrun_error_q)
    else $error("overrun not cleared by disabled reception");

  addr_drop_a: assert property (
    (rx_deliver && addr_drop) |=> $stable(rxbuf_q))
    else $error("address filter let a data character through");

  addr_ninth_a: assert property (
    (deliver_ok && address_detect_enable_q && rx9_q) |=> received_ninth_bit_q)
    else $error("buffered address character lacks ninth bit");

  port_enable_reset_a: assert property (
    !port_enable_q |=> !overrun_error_q && !rx_done_flag_q && !framing_error_q)
    else $error("port disable did not reset receive flags");

  irq_gate_a: assert property (
    irq_q |-> $past(rx_done_flag_q && rx_done_irq_enable_q && peripheral_irq_enable_q && gie_q))
    else $error("interrupt raised without all enables");

  ovr_set_a: assert property (
    (ovr_set && rx_on) |=> overrun_error_q ##1 (st_q == ST_IDLE))
    else $error("overrun not flagged or reception not halted");

  frame_err_a: assert property (
    (deliver_ok && !sync_q) |=> framing_error_q == !$past(dt_s))
    else $error("framing error does not follow stop bit");

endmodule
`default_nettype wire

// ---- hdl/spr_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module spr_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          s1_q[i] <= 1'b1;
          q[i] <= 1'b1;
        end else begin
          s1_q[i] <= d[i];
          q[i] <= s1_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- tb/spr_remote.sv ----
`timescale 1ns/10ps
`default_nettype none
module spr_remote #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk_sys,
  output logic data_pin,
  output logic clk_pin
);
  // Line idles high, clock stands still high between frames
  initial begin
    data_pin = 1'b1;
    clk_pin = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////
  // One bit period on the asynchronous line
  task automatic put_bit(input logic b);
    @(posedge clk_sys);
    data_pin <= b;
    repeat (BIT_CYC - 1) @(posedge clk_sys);
  endtask

  // Start bit, data LSB first, stop bit, then one idle bit
  task automatic send_async(input logic [8:0] v, input int nb, input logic stop);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++) put_bit(v[i]);
    put_bit(stop);
    put_bit(1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////
  // Clocked master: data set while clock high, receiver samples on the fall
  task automatic send_sync(input logic [8:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_sys);
      data_pin <= v[i];
      repeat (3) @(posedge clk_sys);
      clk_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      clk_pin <= 1'b1;
    end
    repeat (3) @(posedge clk_sys);
    // Released line shows no stale value
    data_pin <= ~v[nb-1];
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_serial_port_receiver.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_serial_port_receiver;
  import spr_pkg::*;
  logic clk_sys, rstn, avs_read, avs_write, core_sleep;
  logic avs_waitrequest, wake_req, irq_req, data_pin, clk_pin;
  logic [AW-1:0] avs_address;
  logic [DW-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [AW-1:0] ofs [10] = '{OFS_BAUD_CONTROL, OFS_PERIPHERAL_IRQ_ENABLE_1, OFS_PERIPHERAL_IRQ_FLAGS_1, OFS_RX_DATA, OFS_RX_STATUS,
                              OFS_TX_STATUS, OFS_DIV_LOW, OFS_DIV_HIGH, OFS_IRQ_CONTROL, 6'h3c};
  int n_fail = 0;
  int total_checks = 0;

  spr_rx_top dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sync_data_pin(data_pin),
    .sync_clk_pin(clk_pin), .core_sleep(core_sleep), .wake_req(wake_req), .irq_req(irq_req));
  spr_remote #(.BIT_CYC(4)) rem (.clk_sys(clk_sys), .data_pin(data_pin), .clk_pin(clk_pin));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic chk_val(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // Avalon-MM master: hold request until waitrequest sampled low
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [7:0] wd,
                     input logic [3:0] be, output logic [DW-1:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, 4'hf, rd);
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string m);
    bus(1'b0, a, 8'h00, 4'hf, rd);
    chk_val(rd, exp, m);
  endtask
  task automatic tx_a(input logic [8:0] v, input int nb, input logic stop);
    rem.send_async(v, nb, stop);
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic tx_s(input logic [8:0] v, input int nb);
    rem.send_sync(v, nb);
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    core_sleep = 1'b0;
    repeat (5) @(posedge clk_sys);
    chk_pin(avs_waitrequest, 1'b1, "waitrequest in reset");
    chk_pin(irq_req, 1'b0, "irq in reset");
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (ofs[i]) rd_chk(ofs[i], (i == 0) ? 32'h40 : WORD_ZERO, "reset value");
    wr(6'h3c, 8'hff);
    rd_chk(6'h3c, WORD_ZERO, "unmapped write");
    bus(1'b1, OFS_IRQ_CONTROL, 8'hc0, 4'he, rd);
    rd_chk(OFS_IRQ_CONTROL, WORD_ZERO, "low lane disabled");
    $display("test reset done");
    wr(OFS_DIV_LOW, 8'h00);
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_BAUD_CONTROL, 8'h08);
    wr(OFS_TX_STATUS, 8'h04);
    wr(OFS_RX_STATUS, 8'h80);
    tx_a(9'h055, 8, 1'b1);
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, WORD_ZERO, "char taken while disabled");
    wr(OFS_RX_STATUS, 8'h90);
    tx_a(9'h0a5, 8, 1'b1);
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, 32'h20, "done flag");
    rd_chk(OFS_RX_STATUS, 32'h90, "status clean");
    rd_chk(OFS_RX_DATA, 32'ha5, "data byte");
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, WORD_ZERO, "flag after read");
    $display("test async done");
    wr(OFS_PERIPHERAL_IRQ_ENABLE_1, 8'h20);
    wr(OFS_IRQ_CONTROL, 8'hc0);
    tx_a(9'h03c, 8, 1'b1);
    chk_pin(irq_req, 1'b1, "irq all enables");
    chk_pin(wake_req, 1'b1, "wake request");
    wr(OFS_IRQ_CONTROL, 8'h40);
    repeat (2) @(posedge clk_sys);
    chk_pin(irq_req, 1'b0, "irq without global");
    chk_pin(wake_req, 1'b1, "wake without global");
    rd_chk(OFS_RX_DATA, 32'h3c, "data byte");
    repeat (2) @(posedge clk_sys);
    chk_pin(wake_req, 1'b0, "wake after read");
    $display("test irq done");
    tx_a(9'h0f0, 8, 1'b0);
    rd_chk(OFS_RX_STATUS, 32'h94, "framing set");
    rd_chk(OFS_RX_DATA, 32'hf0, "data byte");
    tx_a(9'h00f, 8, 1'b1);
    rd_chk(OFS_RX_STATUS, 32'h90, "framing updated");
    rd_chk(OFS_RX_DATA, 32'h0f, "data byte");
    $display("test framing done");
    tx_a(9'h011, 8, 1'b1);
    tx_a(9'h022, 8, 1'b1);
    rd_chk(OFS_RX_STATUS, 32'h92, "overrun set");
    rd_chk(OFS_RX_DATA, 32'h11, "first byte kept");
    tx_a(9'h044, 8, 1'b1);
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, WORD_ZERO, "halted after overrun");
    wr(OFS_RX_STATUS, 8'h80);
    rd_chk(OFS_RX_STATUS, 32'h80, "overrun cleared");
    $display("test overrun done");
    wr(OFS_RX_STATUS, 8'hd0);
    tx_a(9'h1c3, 9, 1'b1);
    rd_chk(OFS_RX_STATUS, 32'hd1, "ninth bit");
    rd_chk(OFS_RX_DATA, 32'hc3, "data low bits");
    wr(OFS_RX_STATUS, 8'hd8);
    tx_a(9'h077, 9, 1'b1);
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, WORD_ZERO, "data char filtered");
    tx_a(9'h1a1, 9, 1'b1);
    rd_chk(OFS_RX_STATUS, 32'hd9, "address char");
    rd_chk(OFS_RX_DATA, 32'ha1, "address byte");
    wr(OFS_RX_STATUS, 8'hd0);
    tx_a(9'h05a, 9, 1'b1);
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, 32'h20, "all chars pass");
    rd_chk(OFS_RX_STATUS, 32'hd0, "ninth zero");
    rd_chk(OFS_RX_DATA, 32'h5a, "data byte");
    $display("test nine bit done");
    wr(OFS_RX_STATUS, 8'h00);
    wr(OFS_TX_STATUS, 8'h10);
    wr(OFS_RX_STATUS, 8'hb0);
    rd_chk(OFS_BAUD_CONTROL, 32'h08, "slave never idle");
    core_sleep <= 1'b1;
    tx_s(9'h0c6, 8);
    chk_pin(wake_req, 1'b1, "wake from sleep");
    chk_pin(irq_req, 1'b0, "no vector without global");
    core_sleep <= 1'b0;
    rd_chk(OFS_RX_DATA, 32'hc6, "slave byte");
    wr(OFS_RX_STATUS, 8'hf0);
    tx_s(9'h12d, 9);
    rd_chk(OFS_RX_STATUS, 32'hf1, "slave ninth bit");
    rd_chk(OFS_RX_DATA, 32'h2d, "slave byte");
    tx_s(9'h001, 9);
    tx_s(9'h002, 9);
    rd_chk(OFS_RX_STATUS, 32'hf2, "slave overrun");
    wr(OFS_RX_STATUS, 8'h70);
    rd_chk(OFS_RX_STATUS, 32'h70, "port off clears");
    rd_chk(OFS_PERIPHERAL_IRQ_FLAGS_1, WORD_ZERO, "port off flag");
    $display("test slave done");
    end_of_test();
  end
endmodule
`default_nettype wire
